/* File: include/pbw_defines.svh */
// register offsets, field positions and reset values of the window bridge
`ifndef PBW_DEFINES_SVH
`define PBW_DEFINES_SVH
`define PBW_OFS_WIN1 12'h414
`define PBW_OFS_WIN2 12'h418
`define PBW_OFS_LUT_LO 12'h800
`define PBW_OFS_LUT_HI 12'h9fc
`define PBW_WIN1_RST 32'hf000_0001
`define PBW_WIN2_RST 32'h0000_0000
`define PBW_LUT_RST 32'h0000_0000
`define PBW_BA_HI 31
`define PBW_BA_LO 28
`define PBW_BAU_HI 27
`define PBW_BAU_LO 24
`define PBW_SZ_HI 7
`define PBW_SZ_LO 4
`define PBW_EN_BIT 0
`define PBW_SZ_256M 4'h0
`define PBW_TA_HI 31
`define PBW_TA_LO 23
`define PBW_WP_BIT 7
`define PBW_ATE_BIT 4
`define PBW_PORT_HI 3
`define PBW_PORT_LO 0
`define PBW_PORT_HLP 4'b0000
`define PBW_A_WIN_HI 35
`define PBW_A_WIN_LO 28
`define PBW_A_PG_HI 27
`define PBW_A_PG_LO 23
`define PBW_A_OFS_HI 22
`define PBW_A_IDX_HI 8
`define PBW_A_IDX_LO 2
`endif

/* File: include/pbw_pkg.sv */
// types shared by the window bridge modules
package pbw_pkg;
  typedef enum logic [1:0] {
    PBW_ACC_IDLE = 2'b00,
    PBW_ACC_PB = 2'b01,
    PBW_ACC_PX = 2'b10
  } pbw_acc_t;
  typedef logic [6:0] pbw_lut_idx_t;
  typedef logic [4:0] pbw_page_t;
endpackage

/* File: include/pbw_lut_if.sv */
// interface between the bridge and its page lookup store
`timescale 1ns/1ps
interface pbw_lut_if;
  logic wr_en;
  pbw_pkg::pbw_lut_idx_t wr_idx;
  logic [31:0] wr_data;
  pbw_pkg::pbw_lut_idx_t rd_idx;
  logic [31:0] rd_data;
  logic lk_win;
  pbw_pkg::pbw_page_t lk_page;
  logic [31:0] lk_lower;
  logic [31:0] lk_upper;
  modport owner (output wr_en, wr_idx, wr_data, rd_idx, lk_win, lk_page,
    input rd_data, lk_lower, lk_upper);
  modport store (input wr_en, wr_idx, wr_data, rd_idx, lk_win, lk_page,
    output rd_data, lk_lower, lk_upper);
endinterface

/* File: hw/pbw_page_lut.sv */
// page lookup entry store: two windows, lower and upper entry per page
`timescale 1ns/1ps
`include "pbw_defines.svh"
module pbw_page_lut #(
  parameter int unsigned ENTRIES = 128
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  pbw_lut_if.store lut
);
  logic [31:0] mem_q [ENTRIES];

  for (genvar i = 0; i < ENTRIES; i++)
  begin : g_entry
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
        mem_q[i] <= `PBW_LUT_RST;
      else if (lut.wr_en && lut.wr_idx == 7'(i))
        mem_q[i] <= lut.wr_data;
    end
  end

  assign lut.rd_data = mem_q[lut.rd_idx];
  // entry index is window, page, then upper-entry bit
  assign lut.lk_lower = mem_q[{lut.lk_win, lut.lk_page, 1'b0}];
  assign lut.lk_upper = mem_q[{lut.lk_win, lut.lk_page, 1'b1}];

  property p_lut_store;
    @(posedge core_clk_in) disable iff (!nrst_in)
    lut.wr_en |=> mem_q[$past(lut.wr_idx)] == $past(lut.wr_data);
  endproperty
  a_lut_store: assert property (p_lut_store) else $error("lookup entry not stored");
endmodule // pbw_page_lut

/* File: hw/pbw_window_bridge.sv */
// processor bus inbound window decoder with page lookup translation
// Notes on behaviour
// - claim only requests inside an enabled window; forward each claim to fabric.
// - two window base registers, at 0x414 and 0x418.
// - each window has 32 pages, each with lower and upper lookup entries.
// - lookup entries of both windows lie at 0x800 through 0x9fc.
// - after reset window one is enabled, mapping boot region 0xfff0 to local port.
// - right after power-up window one hits go to the local port regardless.
// - registers writable from the pci/x window route and the processor route.
// - size code zero means 256M window; decode only while enable is set.
// - each window splits into 32 equal pages, 8M each at 256M.
// - address top eight bits compare to upper base nibble and base nibble.
// - next five address bits pick the entry; the rest is page offset.
// - translation enable replaces all bits above the offset with upper entry and target bits, keeps offset.
// - destination port field picks target; code zero is the host local port.
// - local port targets see only the low 32 bits; upper target ignored.
`timescale 1ns/1ps
`include "pbw_defines.svh"
module pbw_window_bridge (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic pb_req_in,
  input wire logic [35:0] pb_addr_in,
  input wire logic pb_write_in,
  output logic pb_claim_out,
  output logic fab_valid_out,
  output logic [63:0] fab_addr_out,
  output logic [3:0] fab_port_out,
  output logic fab_write_out,
  input wire logic pbr_wr_in,
  input wire logic pbr_rd_in,
  input wire logic [11:0] pbr_addr_in,
  input wire logic [31:0] pbr_wdata_in,
  output logic pbr_ack_out,
  output logic [31:0] pbr_rdata_out,
  input wire logic pxr_wr_in,
  input wire logic pxr_rd_in,
  input wire logic [11:0] pxr_addr_in,
  input wire logic [31:0] pxr_wdata_in,
  output logic pxr_ack_out,
  output logic [31:0] pxr_rdata_out,
  output logic boot_mode_out
);
  pbw_lut_if lut ();
  pbw_page_lut u_lut (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .lut(lut)
  );

  logic [31:0] win1_q, win2_q;
  logic boot_q;

  // register access: processor route wins over pci/x route in the same cycle
  pbw_pkg::pbw_acc_t acc_src;
  wire pb_acc = pbr_wr_in | pbr_rd_in;
  wire px_acc = pxr_wr_in | pxr_rd_in;
  assign acc_src = pb_acc ? pbw_pkg::PBW_ACC_PB :
                   px_acc ? pbw_pkg::PBW_ACC_PX : pbw_pkg::PBW_ACC_IDLE;
  wire sel_px = (acc_src == pbw_pkg::PBW_ACC_PX);
  wire [11:0] acc_addr = sel_px ? pxr_addr_in : pbr_addr_in;
  wire [31:0] acc_wdata = sel_px ? pxr_wdata_in : pbr_wdata_in;
  wire acc_wr = sel_px ? pxr_wr_in : (acc_src == pbw_pkg::PBW_ACC_PB) & pbr_wr_in;
  wire hit_w1 = (acc_addr == `PBW_OFS_WIN1);
  wire hit_w2 = (acc_addr == `PBW_OFS_WIN2);
  wire hit_lut = (acc_addr >= `PBW_OFS_LUT_LO) && (acc_addr <= `PBW_OFS_LUT_HI)
                 && (acc_addr[1:0] == 2'b00);
  wire [31:0] acc_rdata = hit_w1 ? win1_q : hit_w2 ? win2_q :
                          hit_lut ? lut.rd_data : 32'h0000_0000;
  assign lut.wr_en = acc_wr & hit_lut;
  assign lut.wr_idx = acc_addr[`PBW_A_IDX_HI:`PBW_A_IDX_LO];
  assign lut.wr_data = acc_wdata;
  assign lut.rd_idx = acc_addr[`PBW_A_IDX_HI:`PBW_A_IDX_LO];

  // window decode on the top eight address bits
  wire [7:0] req_win = pb_addr_in[`PBW_A_WIN_HI:`PBW_A_WIN_LO];
  wire [7:0] w1_base = {win1_q[`PBW_BAU_HI:`PBW_BAU_LO], win1_q[`PBW_BA_HI:`PBW_BA_LO]};
  wire [7:0] w2_base = {win2_q[`PBW_BAU_HI:`PBW_BAU_LO], win2_q[`PBW_BA_HI:`PBW_BA_LO]};
  wire w1_on = win1_q[`PBW_EN_BIT] && (win1_q[`PBW_SZ_HI:`PBW_SZ_LO] == `PBW_SZ_256M);
  wire w2_on = win2_q[`PBW_EN_BIT] && (win2_q[`PBW_SZ_HI:`PBW_SZ_LO] == `PBW_SZ_256M);
  wire w1_hit = w1_on && (req_win == w1_base);
  wire w2_hit = w2_on && (req_win == w2_base);
  assign lut.lk_win = ~w1_hit;
  assign lut.lk_page = pb_addr_in[`PBW_A_PG_HI:`PBW_A_PG_LO];

  wire boot_route = w1_hit & boot_q;
  wire translation_enable = lut.lk_lower[`PBW_ATE_BIT] & ~boot_route;
  wire wr_blocked = lut.lk_lower[`PBW_WP_BIT] & pb_write_in & ~boot_route;
  wire claim = pb_req_in & (w1_hit | w2_hit) & ~wr_blocked;
  wire [3:0] port = boot_route ? `PBW_PORT_HLP
                               : lut.lk_lower[`PBW_PORT_HI:`PBW_PORT_LO];
  wire [63:0] xlat = translation_enable ? {lut.lk_upper, lut.lk_lower[`PBW_TA_HI:`PBW_TA_LO],
                            pb_addr_in[`PBW_A_OFS_HI:0]}
                         : {28'h000_0000, pb_addr_in};
  wire [63:0] fab_addr = (port == `PBW_PORT_HLP) ? {32'h0000_0000, xlat[31:0]} : xlat;

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      win1_q <= `PBW_WIN1_RST;
      win2_q <= `PBW_WIN2_RST;
      boot_q <= 1'b1;
    end
    else
    begin
      if (acc_wr && hit_w1)
        win1_q <= acc_wdata;
      if (acc_wr && hit_w2)
        win2_q <= acc_wdata;
      if (acc_wr && hit_w1)
        boot_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pb_claim_out <= 1'b0;
      fab_valid_out <= 1'b0;
      fab_addr_out <= 64'h0000_0000_0000_0000;
      fab_port_out <= `PBW_PORT_HLP;
      fab_write_out <= 1'b0;
    end
    else
    begin
      pb_claim_out <= claim;
      fab_valid_out <= claim;
      if (claim)
      begin
        fab_addr_out <= fab_addr;
        fab_port_out <= port;
        fab_write_out <= pb_write_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pbr_ack_out <= 1'b0;
      pxr_ack_out <= 1'b0;
      pbr_rdata_out <= 32'h0000_0000;
      pxr_rdata_out <= 32'h0000_0000;
      boot_mode_out <= 1'b1;
    end
    else
    begin
      pbr_ack_out <= (acc_src == pbw_pkg::PBW_ACC_PB);
      pxr_ack_out <= sel_px;
      if ((acc_src == pbw_pkg::PBW_ACC_PB) && pbr_rd_in)
        pbr_rdata_out <= acc_rdata;
      if (sel_px && pxr_rd_in)
        pxr_rdata_out <= acc_rdata;
      boot_mode_out <= boot_q & ~(acc_wr & hit_w1);
    end
  end

  property p_no_claim_outside;
    @(posedge core_clk_in) disable iff (!nrst_in)
    pb_req_in && !w1_hit && !w2_hit |=> !pb_claim_out && !fab_valid_out;
  endproperty
  a_no_claim_outside: assert property (p_no_claim_outside) else $error("claim outside windows");
  property p_claim_fwd;
    @(posedge core_clk_in) disable iff (!nrst_in)
    pb_claim_out |-> fab_valid_out && $past(pb_req_in) && ($past(w1_hit) || $past(w2_hit));
  endproperty
  a_claim_fwd: assert property (p_claim_fwd) else $error("claim not forwarded once");
  property p_boot_local;
    @(posedge core_clk_in) disable iff (!nrst_in)
    pb_req_in && boot_q && w1_on && req_win == w1_base |=> pb_claim_out
      && fab_port_out == `PBW_PORT_HLP && fab_addr_out[35:0] == $past(pb_addr_in);
  endproperty
  a_boot_local: assert property (p_boot_local) else $error("boot access misrouted");
  property p_win2_write;
    @(posedge core_clk_in) disable iff (!nrst_in)
    pbr_wr_in && pbr_addr_in == `PBW_OFS_WIN2 |=> win2_q == $past(pbr_wdata_in) && pbr_ack_out;
  endproperty
  a_win2_write: assert property (p_win2_write) else $error("window two base not written");
  property p_px_write;
    @(posedge core_clk_in) disable iff (!nrst_in)
    pxr_wr_in && !pb_acc && pxr_addr_in == `PBW_OFS_WIN1 |=> win1_q == $past(pxr_wdata_in)
      ##1 !boot_mode_out;
  endproperty
  a_px_write: assert property (p_px_write) else $error("pci/x route write lost");
  property p_size_gate;
    @(posedge core_clk_in) disable iff (!nrst_in)
    pb_req_in && !w1_hit && win2_q[`PBW_SZ_HI:`PBW_SZ_LO] != `PBW_SZ_256M |=> !pb_claim_out;
  endproperty
  a_size_gate: assert property (p_size_gate) else $error("unsupported size decoded");
  property p_translate;
    @(posedge core_clk_in) disable iff (!nrst_in)
    claim && translation_enable |=> fab_addr_out[31:23] == $past(lut.lk_lower[`PBW_TA_HI:`PBW_TA_LO])
      && fab_addr_out[22:0] == $past(pb_addr_in[22:0]);
  endproperty
  a_translate: assert property (p_translate) else $error("translation wrong");
  property p_pass;
    @(posedge core_clk_in) disable iff (!nrst_in)
    claim && !translation_enable |=> fab_addr_out[31:0] == $past(pb_addr_in[31:0]);
  endproperty
  a_pass: assert property (p_pass) else $error("untranslated address altered");
  property p_port;
    @(posedge core_clk_in) disable iff (!nrst_in)
    claim && !boot_route |=> fab_port_out == $past(lut.lk_lower[`PBW_PORT_HI:`PBW_PORT_LO]);
  endproperty
  a_port: assert property (p_port) else $error("destination port wrong");
  property p_local_trunc;
    @(posedge core_clk_in) disable iff (!nrst_in)
    fab_valid_out && fab_port_out == `PBW_PORT_HLP |-> fab_addr_out[63:32] == 32'h0000_0000;
  endproperty
  a_local_trunc: assert property (p_local_trunc) else $error("local port address not 32 bit");
  c_boot: cover property (@(posedge core_clk_in) disable iff (!nrst_in) claim && boot_route);
  c_xlat2: cover property (@(posedge core_clk_in) disable iff (!nrst_in) claim && w2_hit && translation_enable);
  c_miss: cover property (@(posedge core_clk_in) disable iff (!nrst_in) pb_req_in && !claim);
  c_both: cover property (@(posedge core_clk_in) disable iff (!nrst_in) pb_acc && px_acc);
endmodule // pbw_window_bridge

/* File: testbench/pbw_proc_model.sv */
// processor side model that issues requests to the window bridge
`timescale 1ns/1ps
module pbw_proc_model (
  input wire logic clk_in,
  output logic req_out,
  output logic [35:0] addr_out,
  output logic write_out
);
  initial
  begin
    req_out = 1'b0;
    addr_out = 36'h0_0000_0000;
    write_out = 1'b0;
  end
  // one-cycle request; lines show the inverse once released
  task automatic issue(input logic [35:0] a, input logic w);
    @(negedge clk_in);
    req_out = 1'b1;
    addr_out = a;
    write_out = w;
    @(negedge clk_in);
    req_out = 1'b0;
    addr_out = ~a;
    write_out = ~w;
  endtask
endmodule // pbw_proc_model

/* File: testbench/pbw_window_bridge_tb_top.sv */
// self-checking bench for the processor bus window bridge
`timescale 1ns/1ps
module pbw_window_bridge_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pb_req, pb_write, claim, fvalid, fwrite, boot;
  logic [35:0] pb_addr;
  logic [63:0] faddr;
  logic [3:0] fport;
  logic [1:0] wr, rd, ack;
  logic [11:0] ra;
  logic [31:0] wd, rq0, rq1, q;
  int bad_count = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  pbw_proc_model cpu (.clk_in(clk), .req_out(pb_req), .addr_out(pb_addr), .write_out(pb_write));
  pbw_window_bridge uut (
    .core_clk_in(clk), .nrst_in(nrst), .pb_req_in(pb_req), .pb_addr_in(pb_addr),
    .pb_write_in(pb_write), .pb_claim_out(claim), .fab_valid_out(fvalid),
    .fab_addr_out(faddr), .fab_port_out(fport), .fab_write_out(fwrite),
    .pbr_wr_in(wr[0]), .pbr_rd_in(rd[0]), .pbr_addr_in(ra), .pbr_wdata_in(wd),
    .pbr_ack_out(ack[0]), .pbr_rdata_out(rq0), .pxr_wr_in(wr[1]), .pxr_rd_in(rd[1]),
    .pxr_addr_in(ra), .pxr_wdata_in(wd), .pxr_ack_out(ack[1]), .pxr_rdata_out(rq1),
    .boot_mode_out(boot));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // route 0 is the processor window, route 1 the pci/x window
  task automatic acc(input int r, input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] res);
    @(negedge clk);
    wr[r] = w;
    rd[r] = ~w;
    ra = a;
    wd = d;
    @(negedge clk);
    chk({62'h0, ack}, r ? 64'h2 : 64'h1);
    res = r ? rq1 : rq0;
    wr = 2'b00;
    rd = 2'b00;
    ra = ~a;
    wd = ~d;
  endtask
  // both routes write in one cycle: only the processor route is taken
  task automatic both(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 2'b11;
    ra = a;
    wd = d;
    @(negedge clk);
    chk({62'h0, ack}, 64'h1);
    wr = 2'b00;
    ra = ~a;
    wd = ~d;
  endtask
  task automatic wrt(input int r, input logic [11:0] a, input logic [31:0] d);
    acc(r, 1'b1, a, d, q);
  endtask
  task automatic rdc(input int r, input logic [11:0] a, input logic [31:0] e);
    acc(r, 1'b0, a, 32'h0000_0000, q);
    chk({32'h0, q}, {32'h0, e});
  endtask
  task automatic req(input logic [35:0] a, input logic w, input logic c,
      input logic [63:0] ea, input logic [3:0] ep);
    cpu.issue(a, w);
    chk({62'h0, claim, fvalid}, {62'h0, c, c});
    if (c)
    begin
      chk(faddr, ea);
      chk({59'h0, fwrite, fport}, {59'h0, w, ep});
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200us;
    bad_count++;
    summarize;
  end
  initial
  begin
    wr = 2'b00;
    rd = 2'b00;
    ra = 12'h000;
    wd = 32'h0000_0000;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    chk({63'h0, boot}, 64'h1);
    rdc(0, 12'h414, 32'hf000_0001);
    rdc(1, 12'h418, 32'h0000_0000);
    wrt(0, 12'h8f8, 32'h1200_0013);
    req(36'h0_fff0_0040, 1'b0, 1'b1, 64'h0000_0000_fff0_0040, 4'h0);
    req(36'h0_1000_0000, 1'b0, 1'b0, 64'h0, 4'h0);
    wrt(1, 12'h418, 32'h7400_0001);
    rdc(0, 12'h418, 32'h7400_0001);
    wrt(0, 12'h910, 32'hdc00_0010);
    wrt(0, 12'h914, 32'h1234_5678);
    req(36'h4_717f_fffc, 1'b1, 1'b1, 64'h0000_0000_dc7f_fffc, 4'h0);
    req(36'h5_7150_0000, 1'b0, 1'b0, 64'h0, 4'h0);
    wrt(1, 12'h918, 32'hdc00_0002);
    req(36'h4_7180_0000, 1'b0, 1'b1, 64'h0000_0004_7180_0000, 4'h2);
    both(12'h9f8, 32'h0000_0021);
    rdc(1, 12'h9f8, 32'h0000_0021);
    rdc(1, 12'h910, 32'hdc00_0010);
    wrt(1, 12'h9fc, 32'h5a5a_0000);
    rdc(0, 12'h9fc, 32'h5a5a_0000);
    rdc(0, 12'h100, 32'h0000_0000);
    wrt(0, 12'h418, 32'h7400_0011);
    req(36'h4_7150_0000, 1'b0, 1'b0, 64'h0, 4'h0);
    wrt(0, 12'h418, 32'h7400_0000);
    req(36'h4_7150_0000, 1'b0, 1'b0, 64'h0, 4'h0);
    wrt(1, 12'h414, 32'hf000_0001);
    chk({63'h0, boot}, 64'h0);
    req(36'h0_fff0_0040, 1'b0, 1'b1, 64'h0000_0000_1270_0040, 4'h3);
    summarize;
  end
endmodule // pbw_window_bridge_tb_top
